/* File: pkg/ntu_pkg.sv */
package ntu_pkg;

  // Register indices on the plain register port.
  localparam logic [3:0] NTU_IDX_CTRL1  = 4'h0;
  localparam logic [3:0] NTU_IDX_LIMIT  = 4'h1;
  localparam logic [3:0] NTU_IDX_SP     = 4'h2;
  localparam logic [3:0] NTU_IDX_STATUS = 4'h3;
  localparam logic [3:0] NTU_IDX_RESET  = 4'h4;
  localparam logic [3:0] NTU_IDX_OSC    = 4'h5;
  localparam logic [3:0] NTU_IDX_LEVEL  = 4'h6;

  // Field positions in interrupt_control_one.
  localparam int NTU_B_OSC   = 1;
  localparam int NTU_B_STK   = 2;
  localparam int NTU_B_ADR   = 3;
  localparam int NTU_B_MATH  = 4;
  localparam int NTU_B_DIV   = 6;
  localparam int NTU_B_SFT   = 7;
  localparam int NTU_B_COVEN = 8;
  localparam int NTU_B_OVBEN = 9;
  localparam int NTU_B_OVAEN = 10;
  localparam int NTU_B_COVB  = 11;
  localparam int NTU_B_COVA  = 12;
  localparam int NTU_B_OVB   = 13;
  localparam int NTU_B_OVA   = 14;
  // Other registers.
  localparam int NTU_B_OB    = 14;
  localparam int NTU_B_OA    = 15;
  localparam int NTU_B_TRAP_RESET_FLAG = 15;
  localparam int NTU_B_CF    = 3;
  localparam int NTU_B_TRAP_ACTIVE_LEVEL_BIT  = 3;

  localparam logic [15:0] NTU_SP_RESET  = 16'h0800;
  localparam logic [15:0] NTU_ZERO      = 16'h0000;
  localparam logic signed [5:0] NTU_SHIFT_MAX = 6'sh10;

  // Source index: higher index is higher priority.
  localparam int NTU_SRC_MATH = 0;
  localparam int NTU_SRC_STK  = 1;
  localparam int NTU_SRC_ADR  = 2;
  localparam int NTU_SRC_OSC  = 3;
  localparam int NTU_NSRC     = 4;
  localparam int NTU_SOFT_DLY = 2;

  typedef enum logic [3:0] {
    NTU_LVL_NONE = 4'h0,
    NTU_LVL_MATH = 4'hb,
    NTU_LVL_STK  = 4'hc,
    NTU_LVL_ADR  = 4'hd,
    NTU_LVL_OSC  = 4'he
  } ntu_level_t;

  typedef struct packed {
    logic              sp_ea_valid;
    logic              sp_ea_wrap;
    logic [15:0]       sp_ea;
    logic              acc_a_c31;
    logic              acc_b_c31;
    logic              acc_a_c39;
    logic              acc_b_c39;
    logic              sat31_a;
    logic              sat31_b;
    logic              sat39_a;
    logic              sat39_b;
    logic              arith_a;
    logic              arith_b;
    logic              div_zero;
    logic              div_first;
    logic              shift_valid;
    logic signed [5:0] shift_amt;
    logic              word_access;
    logic              bit_indirect;
    logic              ea_lsb;
    logic              unimpl_data;
    logic              unimpl_prog;
    logic              clk_loss;
    logic              monitor_en;
    logic              pll_unlock;
    logic              pll_por_fail;
  } ntu_evt_t;

endpackage : ntu_pkg

/* File: src/ntu_trap_unit.sv */
`timescale 1ns/1ps
// Functional notes
// - Fixed order: oscillator highest, math lowest.
// - Math and stack traps soft, two-cycle sample.
// - Stack pointer resets to 0800; below traps.
// - Limit check off until limit written.
// - Stack addresses above limit or wrapping trap.
// - Stack error sets flag bit 2.
// - Overflow, divide zero, bad shift raise math.
// - Enables at bits 10, 9, 8.
// - Overflow is carry 31, masked by saturation.
// - Catastrophic is carry 39, masked by saturation.
// - Overflow trap sets matching error flags.
// - Divide zero traps only with div_first, flag bit 6.
// - Bad shift traps, flag 7, result dropped.
// - Math flag clears only after causes clear.
// - OA/OB read-only, cleared by accumulator arithmetic.
// - Address and oscillator traps stall execution.
// - Higher trap preempts; lower stays pending.
// - Lower hard trap conflict resets, sets flag.
// - Oscillator fault from monitor or lock loss.
// - Oscillator fault sets bit 1 and clock-fail.
// - Misaligned, unimplemented accesses raise address error.
// - Address error blocks writes, sets bit 3.
// - Trap levels occupy 11 through 14.
// - Level bit held during service; clear only.
module ntu_trap_unit
  import ntu_pkg::*;
(
  input  logic        core_clk,
  input  logic        rst,
  input  logic [3:0]  addr,
  input  logic [15:0] wdata,
  input  logic        wr,
  input  logic        rd,
  output logic [15:0] rdata,
  input  ntu_evt_t    ev,
  input  logic        trap_ack,
  input  logic        return_from_handler_op,
  output logic        trap_req,
  output ntu_level_t  trap_level,
  output logic        hard_stall,
  output logic        write_inhibit,
  output logic        shift_write_inhibit,
  output logic        device_reset_req,
  output logic        trap_active_level_bit
);

  logic [15:0] stack_pointer_reg;
  logic [15:0] stack_limit_reg;
  logic        limit_ok;
  logic        osc_fault_flag;
  logic        stack_fault_flag;
  logic        address_fault_flag;
  logic        math_fault_flag;
  logic        divide_zero_flag;
  logic        shift_range_flag;
  logic        acc_a_ovf_flag;
  logic        acc_b_ovf_flag;
  logic        acc_a_catastrophic_flag;
  logic        acc_b_catastrophic_flag;
  logic        acc_a_ovf_trap_en;
  logic        acc_b_ovf_trap_en;
  logic        catastrophic_ovf_trap_en;
  logic        acc_a_overflow_status;
  logic        acc_b_overflow_status;
  logic        trap_reset_flag;
  logic        clock_fail_flag;
  logic [3:0]  pending;
  logic [3:0]  insvc;
  logic [3:0]  ready;
  logic [3:0]  eligible;
  logic [3:0]  evt;
  logic [1:0]  ack_src;
  logic [15:0] ctrl1_word;

  logic ova_ev, ovb_ev, cova_ev, covb_ev;
  logic div_ev, sft_ev, stk_ev, adr_ev, osc_ev;
  logic math_ev, conflict;
  logic wr_ctrl1, wr_reset, wr_osc, wr_level;
  logic causes_clear;

  function automatic logic [1:0] ntu_top(input logic [3:0] m);
    logic [1:0] r;
    r = 2'h0;
    for (int i = 0; i < NTU_NSRC; i++) begin
      if (m[i]) begin
        r = 2'(i);
      end
    end
    return r;
  endfunction

  function automatic ntu_level_t ntu_lvl(input logic [1:0] s);
    ntu_level_t l;
    case (s)
      2'h0:    l = NTU_LVL_MATH;
      2'h1:    l = NTU_LVL_STK;
      2'h2:    l = NTU_LVL_ADR;
      default: l = NTU_LVL_OSC;
    endcase
    return l;
  endfunction

  assign wr_ctrl1 = wr && (addr == NTU_IDX_CTRL1);
  assign wr_reset = wr && (addr == NTU_IDX_RESET);
  assign wr_osc   = wr && (addr == NTU_IDX_OSC);
  assign wr_level = wr && (addr == NTU_IDX_LEVEL);

  // Saturation makes the carries impossible, so they are masked here.
  assign ova_ev  = ev.acc_a_c31 && !ev.sat31_a;
  assign ovb_ev  = ev.acc_b_c31 && !ev.sat31_b;
  assign cova_ev = ev.acc_a_c39 && !ev.sat31_a && !ev.sat39_a;
  assign covb_ev = ev.acc_b_c39 && !ev.sat31_b && !ev.sat39_b;
  assign div_ev  = ev.div_zero && ev.div_first;
  assign sft_ev  = ev.shift_valid && ((ev.shift_amt > NTU_SHIFT_MAX)
                   || (ev.shift_amt < -NTU_SHIFT_MAX));
  assign math_ev = (ova_ev && acc_a_ovf_trap_en)
                || (ovb_ev && acc_b_ovf_trap_en)
                || ((cova_ev || covb_ev) && catastrophic_ovf_trap_en)
                || div_ev || sft_ev;
  assign stk_ev  = (stack_pointer_reg < NTU_SP_RESET)
                || (ev.sp_ea_valid && (ev.sp_ea_wrap
                || (limit_ok && ev.sp_ea > stack_limit_reg)));
  assign adr_ev  = ((ev.word_access || ev.bit_indirect) && ev.ea_lsb)
                || ev.unimpl_data || ev.unimpl_prog;
  assign osc_ev  = (ev.monitor_en && (ev.clk_loss || ev.pll_por_fail))
                || ev.pll_unlock;
  assign evt = {osc_ev, adr_ev, stk_ev, math_ev};

  // A lower hard trap cannot be taken while the higher one is open.
  assign conflict = adr_ev && (pending[NTU_SRC_OSC]
                                || insvc[NTU_SRC_OSC]);

  // Per-source pending, sampling and service state.
  genvar g;
  generate
    for (g = 0; g < NTU_NSRC; g++) begin : gen_src
      logic [NTU_SOFT_DLY-1:0] smp;
      always_ff @(posedge core_clk) begin
        if (rst || conflict) begin
          pending[g] <= 1'b0;
        end else if (evt[g]) begin
          pending[g] <= 1'b1;
        end else if (trap_ack && trap_req && ack_src == 2'(g)) begin
          pending[g] <= 1'b0;
        end
      end
      always_ff @(posedge core_clk) begin
        if (rst || conflict) begin
          smp <= '0;
        end else begin
          smp <= {smp[NTU_SOFT_DLY-2:0], pending[g]} & {NTU_SOFT_DLY{pending[g]}};
        end
      end
      if (g <= NTU_SRC_STK) begin : gen_soft
        assign ready[g] = pending[g] && smp[NTU_SOFT_DLY-1];
      end else begin : gen_hard
        assign ready[g] = pending[g];
      end
      // Only a strictly higher level may interrupt one in service.
      assign eligible[g] = ready[g] && !(|(insvc >> g));
    end
  endgenerate

  always_ff @(posedge core_clk) begin
    if (rst || conflict) begin
      insvc <= 4'h0;
    end else begin
      if (return_from_handler_op && |insvc) begin
        insvc[ntu_top(insvc)] <= 1'b0;
      end
      if (trap_ack && trap_req) begin
        insvc[ack_src] <= 1'b1;
      end
    end
  end

  // Request towards the core; levels are all above 7.
  always_ff @(posedge core_clk) begin
    if (rst || conflict) begin
      trap_req   <= 1'b0;
      trap_level <= NTU_LVL_NONE;
      ack_src    <= 2'h0;
    end else if (trap_ack && trap_req) begin
      trap_req   <= 1'b0;
      trap_level <= NTU_LVL_NONE;
    end else begin
      trap_req   <= |eligible;
      trap_level <= (|eligible) ? ntu_lvl(ntu_top(eligible))
                                : NTU_LVL_NONE;
      ack_src    <= ntu_top(eligible);
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      hard_stall          <= 1'b0;
      write_inhibit       <= 1'b0;
      shift_write_inhibit <= 1'b0;
      device_reset_req    <= 1'b0;
    end else begin
      // The stall starts on the faulting edge, in the same cycle as pending.
      hard_stall          <= adr_ev || osc_ev
                             || |pending[NTU_SRC_OSC:NTU_SRC_ADR];
      write_inhibit       <= adr_ev || pending[NTU_SRC_ADR];
      shift_write_inhibit <= sft_ev;
      device_reset_req    <= conflict;
    end
  end

  // Level bit: hardware sets on entry, software may only clear.
  always_ff @(posedge core_clk) begin
    if (rst || conflict) begin
      trap_active_level_bit <= 1'b0;
    end else if (trap_ack && trap_req) begin
      trap_active_level_bit <= 1'b1;
    end else if ((wr_level && !wdata[NTU_B_TRAP_ACTIVE_LEVEL_BIT])
                 || (return_from_handler_op && $onehot0(insvc))) begin
      trap_active_level_bit <= 1'b0;
    end
  end

  // Stack registers. The limit is data and is left uninitialised.
  always_ff @(posedge core_clk) begin
    if (rst) begin
      stack_pointer_reg <= NTU_SP_RESET;
      limit_ok          <= 1'b0;
    end else begin
      if (wr && addr == NTU_IDX_SP) begin
        stack_pointer_reg <= wdata;
      end
      if (wr && addr == NTU_IDX_LIMIT) begin
        limit_ok <= 1'b1;
      end
    end
  end

  always_ff @(posedge core_clk) begin
    if (wr && addr == NTU_IDX_LIMIT) begin
      stack_limit_reg <= wdata;
    end
  end

  // Sticky flags: an event in the clearing cycle wins.
  always_ff @(posedge core_clk) begin
    if (rst) begin
      osc_fault_flag          <= 1'b0;
      stack_fault_flag        <= 1'b0;
      address_fault_flag      <= 1'b0;
      divide_zero_flag        <= 1'b0;
      shift_range_flag        <= 1'b0;
      acc_a_ovf_flag          <= 1'b0;
      acc_b_ovf_flag          <= 1'b0;
      acc_a_catastrophic_flag <= 1'b0;
      acc_b_catastrophic_flag <= 1'b0;
    end else begin
      osc_fault_flag <= osc_ev || (osc_fault_flag
        && !(wr_ctrl1 && !wdata[NTU_B_OSC]));
      stack_fault_flag <= stk_ev || (stack_fault_flag
        && !(wr_ctrl1 && !wdata[NTU_B_STK]));
      address_fault_flag <= adr_ev || (address_fault_flag
        && !(wr_ctrl1 && !wdata[NTU_B_ADR]));
      divide_zero_flag <= div_ev || (divide_zero_flag
        && !(wr_ctrl1 && !wdata[NTU_B_DIV]));
      shift_range_flag <= sft_ev || (shift_range_flag
        && !(wr_ctrl1 && !wdata[NTU_B_SFT]));
      acc_a_ovf_flag <= (ova_ev && acc_a_ovf_trap_en) || (acc_a_ovf_flag
        && !(wr_ctrl1 && !wdata[NTU_B_OVA]));
      acc_b_ovf_flag <= (ovb_ev && acc_b_ovf_trap_en) || (acc_b_ovf_flag
        && !(wr_ctrl1 && !wdata[NTU_B_OVB]));
      acc_a_catastrophic_flag <= (cova_ev && catastrophic_ovf_trap_en)
        || (acc_a_catastrophic_flag
        && !(wr_ctrl1 && !wdata[NTU_B_COVA]));
      acc_b_catastrophic_flag <= (covb_ev && catastrophic_ovf_trap_en)
        || (acc_b_catastrophic_flag
        && !(wr_ctrl1 && !wdata[NTU_B_COVB]));
    end
  end

  // Causes are judged on stored state, so software clears them first.
  assign causes_clear = !(divide_zero_flag || shift_range_flag
    || acc_a_ovf_flag || acc_b_ovf_flag || acc_a_catastrophic_flag
    || acc_b_catastrophic_flag || acc_a_overflow_status
    || acc_b_overflow_status);

  always_ff @(posedge core_clk) begin
    if (rst) begin
      math_fault_flag <= 1'b0;
    end else if (math_ev) begin
      math_fault_flag <= 1'b1;
    end else if (wr_ctrl1 && !wdata[NTU_B_MATH] && causes_clear) begin
      math_fault_flag <= 1'b0;
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      acc_a_ovf_trap_en        <= 1'b0;
      acc_b_ovf_trap_en        <= 1'b0;
      catastrophic_ovf_trap_en <= 1'b0;
    end else if (wr_ctrl1) begin
      acc_a_ovf_trap_en        <= wdata[NTU_B_OVAEN];
      acc_b_ovf_trap_en        <= wdata[NTU_B_OVBEN];
      catastrophic_ovf_trap_en <= wdata[NTU_B_COVEN];
    end
  end

  // Read-only overflow status; arithmetic on that accumulator clears unless it overflows.
  always_ff @(posedge core_clk) begin
    if (rst) begin
      acc_a_overflow_status <= 1'b0;
      acc_b_overflow_status <= 1'b0;
    end else begin
      acc_a_overflow_status <= ova_ev
        || (acc_a_overflow_status && !ev.arith_a);
      acc_b_overflow_status <= ovb_ev
        || (acc_b_overflow_status && !ev.arith_b);
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      trap_reset_flag <= 1'b0;
      clock_fail_flag <= 1'b0;
    end else begin
      trap_reset_flag <= conflict || (trap_reset_flag
        && !(wr_reset && !wdata[NTU_B_TRAP_RESET_FLAG]));
      clock_fail_flag <= osc_ev || (clock_fail_flag
        && !(wr_osc && !wdata[NTU_B_CF]));
    end
  end

  always_comb begin
    ctrl1_word              = NTU_ZERO;
    ctrl1_word[NTU_B_OSC]   = osc_fault_flag;
    ctrl1_word[NTU_B_STK]   = stack_fault_flag;
    ctrl1_word[NTU_B_ADR]   = address_fault_flag;
    ctrl1_word[NTU_B_MATH]  = math_fault_flag;
    ctrl1_word[NTU_B_DIV]   = divide_zero_flag;
    ctrl1_word[NTU_B_SFT]   = shift_range_flag;
    ctrl1_word[NTU_B_COVEN] = catastrophic_ovf_trap_en;
    ctrl1_word[NTU_B_OVBEN] = acc_b_ovf_trap_en;
    ctrl1_word[NTU_B_OVAEN] = acc_a_ovf_trap_en;
    ctrl1_word[NTU_B_COVB]  = acc_b_catastrophic_flag;
    ctrl1_word[NTU_B_COVA]  = acc_a_catastrophic_flag;
    ctrl1_word[NTU_B_OVB]   = acc_b_ovf_flag;
    ctrl1_word[NTU_B_OVA]   = acc_a_ovf_flag;
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      rdata <= NTU_ZERO;
    end else if (rd) begin
      rdata <= NTU_ZERO;
      case (addr)
        NTU_IDX_CTRL1: rdata <= ctrl1_word;
        NTU_IDX_LIMIT: rdata <= stack_limit_reg;
        NTU_IDX_SP:    rdata <= stack_pointer_reg;
        NTU_IDX_STATUS: begin
          rdata[NTU_B_OA] <= acc_a_overflow_status;
          rdata[NTU_B_OB] <= acc_b_overflow_status;
        end
        NTU_IDX_RESET: rdata[NTU_B_TRAP_RESET_FLAG] <= trap_reset_flag;
        NTU_IDX_OSC:   rdata[NTU_B_CF]    <= clock_fail_flag;
        NTU_IDX_LEVEL: rdata[NTU_B_TRAP_ACTIVE_LEVEL_BIT]  <= trap_active_level_bit;
        default:       rdata <= NTU_ZERO;
      endcase
    end else begin
      rdata <= NTU_ZERO;
    end
  end

  default clocking cb @(posedge core_clk); endclocking
  default disable iff (rst);

  a_math_low_rank: assert property (
    trap_req && trap_level == NTU_LVL_MATH
      |-> $past(pending[NTU_SRC_OSC:NTU_SRC_ADR]) == 2'h0)
    else $error("Math trap offered over a pending hard trap.");

  a_soft_sample: assert property (
    trap_req && trap_level == NTU_LVL_STK
      |-> $past(pending[NTU_SRC_STK], 2))
    else $error("Stack trap offered before two sample cycles.");

  a_sp_reset_val: assert property (
    disable iff (1'b0)
      $past(rst) && !rst |-> stack_pointer_reg == NTU_SP_RESET)
    else $error("Stack pointer not at its reset value.");

  a_limit_gated: assert property (
    !limit_ok && ev.sp_ea_valid && !ev.sp_ea_wrap && !stack_fault_flag
      && stack_pointer_reg >= NTU_SP_RESET |=> !stack_fault_flag)
    else $error("Limit compare active before limit written.");

  a_wrap_trap: assert property (
    ev.sp_ea_valid && ev.sp_ea_wrap |=> stack_fault_flag)
    else $error("Stack wrap did not flag a stack error.");

  a_sat_masks: assert property (
    ev.sat31_a && !acc_a_overflow_status |=> !acc_a_overflow_status)
    else $error("Overflow reported under saturation.");

  a_div_flags: assert property (
    ev.div_zero && ev.div_first |=> divide_zero_flag && math_fault_flag)
    else $error("Divide by zero not flagged.");

  a_shift_drop: assert property (
    sft_ev |=> shift_range_flag && shift_write_inhibit)
    else $error("Bad shift not flagged or not inhibited.");

  a_oa_clear: assert property (
    ev.arith_a && !ova_ev |=> !acc_a_overflow_status)
    else $error("Arithmetic did not clear overflow status.");

  a_conflict_rst: assert property (
    conflict |=> device_reset_req && trap_reset_flag && !trap_req)
    else $error("Hard trap conflict did not reset.");

  a_addr_inhibit: assert property (
    adr_ev |=> write_inhibit && address_fault_flag && hard_stall)
    else $error("Address error did not inhibit writes.");

endmodule // ntu_trap_unit

/* File: sim/ntu_core_model.sv */
`timescale 1ns/1ps
// Core side: takes each offered trap after ack_dly+1 cycles and leaves each
// handler after a fixed service time; a preempting trap restarts it.
module ntu_core_model (
  input  logic       core_clk,
  input  logic       rst,
  input  logic       trap_req,
  input  logic [3:0] ack_dly,
  output logic       trap_ack,
  output logic       return_from_handler_op
);
  logic [3:0] wait_cnt;
  logic [3:0] svc_cnt;
  logic [2:0] depth;

  always_ff @(posedge core_clk) begin
    if (rst) begin
      trap_ack               <= 1'b0;
      return_from_handler_op <= 1'b0;
      wait_cnt               <= 4'h0;
      svc_cnt                <= 4'h0;
      depth                  <= 3'h0;
    end else begin
      trap_ack               <= 1'b0;
      return_from_handler_op <= 1'b0;
      if (trap_req && !trap_ack) begin
        wait_cnt <= wait_cnt + 4'h1;
        if (wait_cnt == ack_dly) begin
          trap_ack <= 1'b1;
          wait_cnt <= 4'h0;
          depth    <= depth + 3'h1;
          svc_cnt  <= 4'h0;
        end
      end else begin
        wait_cnt <= 4'h0;
        svc_cnt  <= svc_cnt + 4'h1;
        if (depth != 3'h0 && svc_cnt == 4'h5) begin
          return_from_handler_op <= 1'b1;
          depth                  <= depth - 3'h1;
          svc_cnt                <= 4'h0;
        end
      end
    end
  end
endmodule // ntu_core_model

/* File: sim/ntu_trap_unit_tb.sv */
`timescale 1ns/1ps
module ntu_trap_unit_tb
  import ntu_pkg::*;
;
  logic        core_clk = 1'b0;
  logic        rst      = 1'b1;
  logic [3:0]  addr     = 4'h0;
  logic [15:0] wdata    = 16'h0000;
  logic        wr       = 1'b0;
  logic        rd       = 1'b0;
  logic [3:0]  ack_dly  = 4'h2;
  ntu_evt_t    ev       = '0;
  ntu_evt_t    e;
  ntu_level_t  trap_level;
  logic [15:0] rdata;
  logic [15:0] lfsr     = 16'h8c68;
  logic [15:0] x;
  logic        trap_ack, ret_op, trap_req, hard_stall, write_inhibit;
  logic        shift_wi, dev_rst, lvl_bit;
  logic [3:0]  acked[$];
  int          n_fail     = 0;
  int          num_checks = 0;
  int          lh, ls, i;

  always #5 core_clk = ~core_clk;

  ntu_trap_unit u_ntu_trap_unit (
    .core_clk               (core_clk),
    .rst                    (rst),
    .addr                   (addr),
    .wdata                  (wdata),
    .wr                     (wr),
    .rd                     (rd),
    .rdata                  (rdata),
    .ev                     (ev),
    .trap_ack               (trap_ack),
    .return_from_handler_op (ret_op),
    .trap_req               (trap_req),
    .trap_level             (trap_level),
    .hard_stall             (hard_stall),
    .write_inhibit          (write_inhibit),
    .shift_write_inhibit    (shift_wi),
    .device_reset_req       (dev_rst),
    .trap_active_level_bit  (lvl_bit)
  );

  ntu_core_model u_ntu_core_model (
    .core_clk               (core_clk),
    .rst                    (rst),
    .trap_req               (trap_req),
    .ack_dly                (ack_dly),
    .trap_ack               (trap_ack),
    .return_from_handler_op (ret_op)
  );

  always @(posedge core_clk) begin
    if ({trap_ack, trap_req} === 2'b11) begin
      acked.push_back(trap_level);
    end
  end

  function automatic logic [15:0] lfsr_next(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction

  function automatic logic shift_bad(input logic signed [5:0] a);
    return a > 6'sh10 || a < -6'sh10;
  endfunction

  task automatic chk(input string nm, input logic [15:0] s, input logic [15:0] ex);
    num_checks++;
    if (s !== ex) begin
      n_fail++;
      $display("[ERR] %s expected %h seen %h", nm, ex, s);
    end
  endtask

  task automatic tick;
    @(posedge core_clk);
    #1;
  endtask

  task automatic wreg(input logic [3:0] a, input logic [15:0] d);
    @(posedge core_clk);
    wr    <= 1'b1;
    addr  <= a;
    wdata <= d;
    @(posedge core_clk);
    wr <= 1'b0;
  endtask

  task automatic rchk(input logic [3:0] a, input logic [15:0] m, input logic [15:0] ex);
    @(posedge core_clk);
    rd   <= 1'b1;
    addr <= a;
    @(posedge core_clk);
    rd <= 1'b0;
    #1;
    chk($sformatf("reg%0h", a), rdata & m, ex);
  endtask

  task automatic pulse(input ntu_evt_t p);
    @(posedge core_clk);
    ev <= p;
    @(posedge core_clk);
    ev <= '0;
    #1;
  endtask

  task automatic lat(output int n);
    n = 0;
    while (trap_req !== 1'b1 && n < 20) begin
      tick();
      n++;
    end
  endtask

  // Waits until no trap is offered, stalled or in service for 8 cycles.
  task automatic idle;
    int q;
    q = 0;
    for (int k = 0; k < 120 && q < 8; k++) begin
      tick();
      if ({trap_req, lvl_bit, hard_stall} !== 3'b000) q = 0;
      else q++;
    end
    chk("idle", 16'(q), 16'h0008);
  endtask

  task automatic clr;
    wreg(NTU_IDX_CTRL1, 16'h0000);
    wreg(NTU_IDX_CTRL1, 16'h0000);
  endtask

  task automatic print_verdict;
    $display("checks %0d failures %0d", num_checks, n_fail);
    if (n_fail == 0 && num_checks > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  // The whole sequence needs under 1000 cycles; the limit allows 30000.
  initial begin
    #300000;
    n_fail++;
    print_verdict();
  end

  initial begin
    repeat (5) @(posedge core_clk);
    rst <= 1'b0;
    rchk(NTU_IDX_SP, 16'hffff, NTU_SP_RESET);
    wreg(4'hf, 16'hffff);
    rchk(4'hf, 16'hffff, 16'h0000);
    rchk(NTU_IDX_CTRL1, 16'hffff, 16'h0000);
    pulse('{unimpl_data: 1'b1, default: '0});
    chk("inhibit", {15'h0, write_inhibit}, 16'h0001);
    chk("stall", {15'h0, hard_stall}, 16'h0001);
    lat(lh);
    chk("adr_lvl", {12'h0, trap_level}, {12'h0, NTU_LVL_ADR});
    for (int k = 0; k < 20 && trap_ack !== 1'b1; k++) tick();
    tick();
    chk("in_svc", {15'h0, lvl_bit}, 16'h0001);
    tick();
    chk("resumed", {15'h0, hard_stall}, 16'h0000);
    idle();
    rchk(NTU_IDX_CTRL1, 16'hffff, 16'h0008);
    clr();
    wreg(NTU_IDX_LEVEL, 16'h0008);
    rchk(NTU_IDX_LEVEL, 16'h0008, 16'h0000);
    pulse('{div_zero: 1'b1, default: '0});
    idle();
    rchk(NTU_IDX_CTRL1, 16'hffff, 16'h0000);
    pulse('{div_zero: 1'b1, div_first: 1'b1, default: '0});
    lat(ls);
    chk("soft_gap", 16'(ls - lh), 16'h0002);
    chk("math_lvl", {12'h0, trap_level}, 16'h000b);
    idle();
    rchk(NTU_IDX_CTRL1, 16'hffff, 16'h0050);
    wreg(NTU_IDX_CTRL1, 16'h0000);
    rchk(NTU_IDX_CTRL1, 16'hffff, 16'h0010);
    wreg(NTU_IDX_CTRL1, 16'h0000);
    rchk(NTU_IDX_CTRL1, 16'hffff, 16'h0000);
    wreg(NTU_IDX_CTRL1, 16'h0400);
    pulse('{acc_a_c31: 1'b1, sat31_a: 1'b1, default: '0});
    idle();
    rchk(NTU_IDX_CTRL1, 16'hffff, 16'h0400);
    pulse('{acc_a_c31: 1'b1, default: '0});
    idle();
    rchk(NTU_IDX_CTRL1, 16'hffff, 16'h4410);
    rchk(NTU_IDX_STATUS, 16'hffff, 16'h8000);
    clr();
    rchk(NTU_IDX_CTRL1, 16'hffff, 16'h0010);
    pulse('{arith_a: 1'b1, default: '0});
    rchk(NTU_IDX_STATUS, 16'hffff, 16'h0000);
    wreg(NTU_IDX_CTRL1, 16'h0000);
    rchk(NTU_IDX_CTRL1, 16'hffff, 16'h0000);
    wreg(NTU_IDX_CTRL1, 16'h0300);
    pulse('{acc_b_c31: 1'b1, acc_b_c39: 1'b1, default: '0});
    idle();
    rchk(NTU_IDX_CTRL1, 16'hffff, 16'h2b10);
    rchk(NTU_IDX_STATUS, 16'h4000, 16'h4000);
    pulse('{arith_b: 1'b1, default: '0});
    clr();
    pulse('{sp_ea_valid: 1'b1, sp_ea: 16'h2000, default: '0});
    idle();
    rchk(NTU_IDX_CTRL1, 16'hffff, 16'h0000);
    wreg(NTU_IDX_LIMIT, 16'h1000);
    pulse('{sp_ea_valid: 1'b1, sp_ea: 16'h1000, default: '0});
    idle();
    rchk(NTU_IDX_CTRL1, 16'hffff, 16'h0000);
    pulse('{sp_ea_valid: 1'b1, sp_ea: 16'h1002, default: '0});
    lat(ls);
    chk("stk_lvl", {12'h0, trap_level}, 16'h000c);
    idle();
    rchk(NTU_IDX_CTRL1, 16'hffff, 16'h0004);
    clr();
    wreg(NTU_IDX_SP, 16'h07fe);
    wreg(NTU_IDX_SP, 16'h0800);
    idle();
    rchk(NTU_IDX_CTRL1, 16'h0004, 16'h0004);
    clr();
    for (i = 0; i < 8; i++) begin
      lfsr = lfsr_next(lfsr);
      e = '{shift_valid: 1'b1, default: '0};
      e.shift_amt = (i == 0) ? 6'sh10 : (i == 1) ? 6'sh11 :
                    (i == 2) ? 6'sh2f : lfsr[5:0];
      pulse(e);
      chk("sft_inh", {15'h0, shift_wi}, {15'h0, shift_bad(e.shift_amt)});
      idle();
      rchk(NTU_IDX_CTRL1, 16'h0080, {8'h0, shift_bad(e.shift_amt), 7'h0});
      clr();
    end
    for (i = 0; i < 8; i++) begin
      case (i)
        0: e = '{clk_loss: 1'b1, default: '0};
        1: e = '{clk_loss: 1'b1, monitor_en: 1'b1, default: '0};
        2: e = '{pll_unlock: 1'b1, default: '0};
        3: e = '{pll_por_fail: 1'b1, monitor_en: 1'b1, default: '0};
        4: e = '{word_access: 1'b1, ea_lsb: 1'b1, default: '0};
        5: e = '{bit_indirect: 1'b1, ea_lsb: 1'b1, default: '0};
        6: e = '{unimpl_prog: 1'b1, default: '0};
        default: e = '{word_access: 1'b1, default: '0};
      endcase
      pulse(e);
      idle();
      x = (i == 0 || i == 7) ? 16'h0000 : (i < 4) ? 16'h0002 : 16'h0008;
      rchk(NTU_IDX_CTRL1, 16'h000a, x);
      clr();
    end
    acked.delete();
    ack_dly <= 4'h3;
    pulse('{clk_loss: 1'b1, monitor_en: 1'b1, sp_ea_valid: 1'b1,
            sp_ea: 16'h0900, sp_ea_wrap: 1'b1, div_zero: 1'b1,
            div_first: 1'b1, default: '0});
    idle();
    chk("n_acked", 16'(acked.size()), 16'h0003);
    if (acked.size() == 3) begin
      chk("first", {12'h0, acked[0]}, 16'h000e);
      chk("second", {12'h0, acked[1]}, 16'h000c);
      chk("third", {12'h0, acked[2]}, 16'h000b);
    end
    rchk(NTU_IDX_CTRL1, 16'hffff, 16'h0056);
    rchk(NTU_IDX_OSC, 16'h0008, 16'h0008);
    clr();
    ack_dly <= 4'hf;
    pulse('{clk_loss: 1'b1, monitor_en: 1'b1, default: '0});
    pulse('{unimpl_data: 1'b1, default: '0});
    for (int k = 0; k < 10 && dev_rst !== 1'b1; k++) tick();
    chk("conflict", {15'h0, dev_rst}, 16'h0001);
    rchk(NTU_IDX_RESET, 16'h8000, 16'h8000);
    print_verdict();
  end
endmodule // ntu_trap_unit_tb
